// *** tof_interrupt_and_overflow_limits.sv ***
// Interrupt status, interrupt enables and counter overflow limits
// of a time-to-digital converter measurement sequencer.
// Assumes one 100 MHz clock, synchronous start/stop/tick inputs and
// a register master that holds each strobe for one cycle.
// Limits hit on equality only; a passed limit is met after wrap.
//
// Function
// - Status bit 4 sets when the sequence ends on a stop edge, not on a limit; write one clears.
// - Status bit 3 sets on start edge as measurement begins; write one clears.
// - Clock counter reaching its limit sets bit 2 and stops measurement at once.
// - Coarse counter reaching its limit sets bit 1 and stops measurement at once.
// - Status bit 0 sets when a new measurement completes.
// - Interrupt bits stay set until a one is written; zero leaves them.
// - Status resets to zero; bits 7 to 5 read zero and do nothing.
// - Enable register at 03h resets to 07h; bits 7 to 3 reserved.
// - Enable bit one passes its interrupt to the pin; zero blocks it.
// - Disabled interrupt keeps pin quiet but its status bit still sets.
// - Coarse limit is 16 bits, high at 04h, low at 05h, reset FFh.
// - Clock limit is 16 bits, high at 06h, low at 07h, reset FFh.
// - Writing one to the begin bit clears all status before starting.
`timescale 1ns/1ps
`default_nettype none
`include "tof_irq_defs.svh"

module tof_interrupt_and_overflow_limits (
	input wire logic i_clk, // 100 MHz reference clock
	input wire logic i_rst_n, // Asynchronous reset, active low
	input wire tof_irq_pkg::byte_t i_addr, // Register address
	input wire tof_irq_pkg::byte_t i_wdata, // Register write data
	input wire logic i_wr, // Write strobe, one cycle
	input wire logic i_rd, // Read strobe, one cycle
	output var tof_irq_pkg::byte_t o_rdata, // Read data, cycle after strobe
	input wire logic i_start, // Start signal, rising edge begins
	input wire logic i_stop, // Stop signal, rising edge ends
	input wire logic i_coarse_tick, // Coarse counter advance pulse
	output logic o_trigger, // One-cycle trigger on sequence begin
	output logic o_running, // Measurement between start and stop
	output logic o_irq_pin_n, // Interrupt pin, active low
	output var tof_irq_pkg::word_t o_clock_count, // Live clock counter
	output var tof_irq_pkg::word_t o_coarse_count // Live coarse counter
);
	import tof_irq_pkg::*;

	// ****************************************
	// Storage
	// ****************************************
	seq_state_t state_q;
	seq_state_t state_d;
	logic [`STATUS_WIDTH-1:0] status_q;
	logic [`STATUS_WIDTH-1:0] status_d;
	logic [`ENABLE_WIDTH-1:0] enable_q;
	logic [`ENABLE_WIDTH-1:0] enable_d;
	byte_t coarse_hi_q;
	byte_t coarse_lo_q;
	byte_t clock_hi_q;
	byte_t clock_lo_q;
	logic begin_q;
	logic begin_d;
	logic start_prev_q;
	logic stop_prev_q;
	word_t clk_cnt_q;
	word_t clk_cnt_d;
	word_t coarse_cnt_q;
	word_t coarse_cnt_d;
	byte_t rdata_q;
	byte_t rdata_d;
	logic trigger_q;
	logic running_q;
	logic irq_n_q;

	// ****************************************
	// Address decode
	// ****************************************
	wire sel_ctrl = (i_addr == `OFS_CONTROL);
	wire sel_status = (i_addr == `OFS_INT_STATUS);
	wire sel_enable = (i_addr == `OFS_INT_ENABLE);
	wire sel_cr_hi = (i_addr == `OFS_COARSE_LIMIT_HIGH);
	wire sel_cr_lo = (i_addr == `OFS_COARSE_LIMIT_LOW);
	wire sel_ck_hi = (i_addr == `OFS_CLOCK_LIMIT_HIGH);
	wire sel_ck_lo = (i_addr == `OFS_CLOCK_LIMIT_LOW);

	wire wr_status = i_wr & sel_status;
	wire wr_enable = i_wr & sel_enable;
	// Writing zero to the begin bit has no effect
	wire begin_wr = i_wr & sel_ctrl & i_wdata[`BIT_BEGIN_SEQUENCE];

	// ****************************************
	// Limit write enables
	// ****************************************
	// Limit bytes load independently, with no shadow copy
	wire wr_cr_hi = i_wr & sel_cr_hi;
	wire wr_cr_lo = i_wr & sel_cr_lo;
	wire wr_ck_hi = i_wr & sel_ck_hi;
	wire wr_ck_lo = i_wr & sel_ck_lo;

	// ****************************************
	// Edges and limits
	// ****************************************
	wire start_edge = i_start & ~start_prev_q;
	wire stop_edge = i_stop & ~stop_prev_q;

	// Upper byte is the most significant part
	wire [15:0] coarse_limit = {coarse_hi_q, coarse_lo_q};
	wire [15:0] clock_limit = {clock_hi_q, clock_lo_q};

	wire in_run = (state_q == ST_RUN);
	// A limit of 1 would end a run on the first tick
	wire coarse_hit = in_run & (coarse_cnt_q == coarse_limit);
	wire clock_hit = in_run & (clk_cnt_q == clock_limit);
	wire any_hit = coarse_hit | clock_hit;
	wire began = (state_q == ST_ARMED) & start_edge & ~begin_wr;
	wire finished = in_run & stop_edge & ~any_hit & ~begin_wr;
	// Either way out of a run drops the begin bit
	wire run_end = in_run & (any_hit | stop_edge);

	// ****************************************
	// Status event vector
	// ****************************************
	wire set_begun = began;
	wire set_clock = clock_hit & ~begin_wr;
	wire set_coarse = coarse_hit & ~begin_wr;
	wire set_result = finished;
	wire set_done = finished;

	wire [`STATUS_WIDTH-1:0] status_set = {
		set_done,
		set_begun,
		set_clock,
		set_coarse,
		set_result
	};

	// Begin write wipes everything, else write-one-to-clear
	wire [`STATUS_WIDTH-1:0] status_clr =
		begin_wr ? {`STATUS_WIDTH{1'b1}} :
		wr_status ? i_wdata[`STATUS_WIDTH-1:0] :
		{`STATUS_WIDTH{1'b0}};

	// Set wins over a status write clear in the same cycle; a begin write clears all
	assign status_d = (status_q & ~status_clr) | status_set;

	// Reserved enable bits are not stored and read zero
	assign enable_d = wr_enable ? i_wdata[`ENABLE_WIDTH-1:0] : enable_q;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				state_d = ST_IDLE;
			end
			ST_ARMED: begin
				if (start_edge) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				// Overflow ends the run before any stop
				if (any_hit || stop_edge) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// A new begin restarts from any state
		if (begin_wr) begin
			state_d = ST_ARMED;
		end
	end

	// Begin bit reads one until the sequence ends either way
	assign begin_d = begin_wr ? 1'b1 : (run_end ? 1'b0 : begin_q);
	wire running_d = (state_d == ST_RUN);

	// ****************************************
	// Counters
	// ****************************************
	// Counters run only while measuring; zeroed on start edge
	// No saturation: a count wraps at 16 bits if no limit is met
	assign clk_cnt_d = began ? 16'h0000 :
		((in_run && !any_hit) ? clk_cnt_q + 16'h0001 : clk_cnt_q);
	assign coarse_cnt_d = began ? 16'h0000 :
		((in_run && !any_hit && i_coarse_tick) ?
		coarse_cnt_q + 16'h0001 : coarse_cnt_q);

	// ****************************************
	// Read mux
	// ****************************************
	wire [7:0] rd_ctrl = {7'h00, begin_q};
	wire [7:0] rd_status = {3'h0, status_q};
	wire [7:0] rd_enable = {5'h00, enable_q};

	always_comb begin
		rdata_d = 8'h00;
		if (i_rd) begin
			if (sel_ctrl) begin
				rdata_d = rd_ctrl;
			end else if (sel_status) begin
				rdata_d = rd_status;
			end else if (sel_enable) begin
				rdata_d = rd_enable;
			end else if (sel_cr_hi) begin
				rdata_d = coarse_hi_q;
			end else if (sel_cr_lo) begin
				rdata_d = coarse_lo_q;
			end else if (sel_ck_hi) begin
				rdata_d = clock_hi_q;
			end else if (sel_ck_lo) begin
				rdata_d = clock_lo_q;
			end
		end
	end

	// ****************************************
	// Interrupt pin
	// ****************************************
	// Only the three maskable bits reach the pin
	wire irq_n_d = ~|(status_d[`ENABLE_WIDTH-1:0] & enable_d);

	// ****************************************
	// Sequencer flip-flops
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			begin_q <= 1'b0;
		end else begin
			begin_q <= begin_d;
		end
	end

	// Edge detectors reset to the idle low level, so no false edge
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_prev_q <= 1'b0;
			stop_prev_q <= 1'b0;
		end else begin
			start_prev_q <= i_start;
			stop_prev_q <= i_stop;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			trigger_q <= 1'b0;
		end else begin
			trigger_q <= begin_wr;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			running_q <= 1'b0;
		end else begin
			running_q <= running_d;
		end
	end

	// ****************************************
	// Status and enable flip-flops
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_q <= `RST_INT_STATUS;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			enable_q <= `RST_INT_ENABLE;
		end else begin
			enable_q <= enable_d;
		end
	end

	// Pin registered beside status, so both move on one edge
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_n_q <= 1'b1;
		end else begin
			irq_n_q <= irq_n_d;
		end
	end

	// ****************************************
	// Limit flip-flops
	// ****************************************
	// A limit lowered below a running count is only met after wrap
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			coarse_hi_q <= `RST_LIMIT_BYTE;
		end else if (wr_cr_hi) begin
			coarse_hi_q <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			coarse_lo_q <= `RST_LIMIT_BYTE;
		end else if (wr_cr_lo) begin
			coarse_lo_q <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clock_hi_q <= `RST_LIMIT_BYTE;
		end else if (wr_ck_hi) begin
			clock_hi_q <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clock_lo_q <= `RST_LIMIT_BYTE;
		end else if (wr_ck_lo) begin
			clock_lo_q <= i_wdata;
		end
	end

	// ****************************************
	// Counter and read data flip-flops
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clk_cnt_q <= 16'h0000;
		end else begin
			clk_cnt_q <= clk_cnt_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			coarse_cnt_q <= 16'h0000;
		end else begin
			coarse_cnt_q <= coarse_cnt_d;
		end
	end

	// Read data stands one cycle, zero otherwise
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_rdata = rdata_q;
	assign o_trigger = trigger_q;
	assign o_running = running_q;
	assign o_irq_pin_n = irq_n_q;
	assign o_clock_count = clk_cnt_q;
	assign o_coarse_count = coarse_cnt_q;

endmodule : tof_interrupt_and_overflow_limits

`default_nettype wire

// *** tof_irq_defs.svh ***
// Register offsets, field positions and reset values of the
// interrupt, enable and overflow-limit block.
// Assumes an 8-bit register port with byte addresses.
`ifndef TOF_IRQ_DEFS_SVH
`define TOF_IRQ_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CONTROL 8'h00
`define OFS_INT_STATUS 8'h02
`define OFS_INT_ENABLE 8'h03
`define OFS_COARSE_LIMIT_HIGH 8'h04
`define OFS_COARSE_LIMIT_LOW 8'h05
`define OFS_CLOCK_LIMIT_HIGH 8'h06
`define OFS_CLOCK_LIMIT_LOW 8'h07

// ****************************************
// Field positions
// ****************************************
`define BIT_BEGIN_SEQUENCE 0
`define BIT_NEW_RESULT 0
`define BIT_COARSE_LIMIT 1
`define BIT_CLOCK_LIMIT 2
`define BIT_SEQUENCE_BEGUN 3
`define BIT_SEQUENCE_DONE 4
`define STATUS_WIDTH 5
`define ENABLE_WIDTH 3

// ****************************************
// Reset values
// ****************************************
`define RST_INT_STATUS 5'h00
`define RST_INT_ENABLE 3'h7
`define RST_LIMIT_BYTE 8'hFF

`endif

// *** tof_irq_pkg.sv ***
// Types shared by the interrupt and overflow-limit block.
// Assumes tof_irq_defs.svh for all numeric constants.
package tof_irq_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] word_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_RUN = 2'b10
	} seq_state_t;
endpackage : tof_irq_pkg

// *** tof_irq_monitor.sv ***
// Port checks for the interrupt and limit block.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tof_irq_monitor (
	input wire logic i_clk, // Clock
	input wire logic i_rst_n, // Reset
	input wire tof_irq_pkg::byte_t i_addr, // Address
	input wire tof_irq_pkg::byte_t i_wdata, // Data in
	input wire logic i_wr, // Write
	input wire logic i_rd, // Read
	input wire tof_irq_pkg::byte_t o_rdata, // Data out
	input wire logic i_start, // Start
	input wire logic i_stop, // Stop
	input wire logic o_trigger, // Trigger
	input wire logic o_running, // Running
	input wire logic o_irq_pin_n // Pin
);
	import tof_irq_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ********
	// Checks
	// ********
	sequence begin_wr;
		i_wr && i_addr == 8'h00 && i_wdata[0];
	endsequence
	trig_on_begin_a: assert property (
		begin_wr |=> o_trigger) else $error("no trigger");
	begin_clears_a: assert property (
		begin_wr ##1 (i_rd && i_addr == 8'h02) |=> o_rdata == 8'h00)
		else $error("status not cleared");
	pin_idle_a: assert property (
		begin_wr |=> o_irq_pin_n) else $error("pin low after begin");
	status_rsvd_a: assert property (
		i_rd && i_addr == 8'h02 |=> o_rdata[7:5] == 3'h0)
		else $error("status spare bits set");
	enable_rsvd_a: assert property (
		i_rd && i_addr == 8'h03 |=> o_rdata[7:3] == 5'h00)
		else $error("enable spare bits set");
	run_on_start_a: assert property (
		$rose(o_running) |-> $past(i_start) && !$past(i_start, 2))
		else $error("run without start edge");
	stop_ends_a: assert property (
		o_running && $rose(i_stop) |=> !o_running) else $error("run kept");
	masked_quiet_a: assert property (
		i_wr && i_addr == 8'h03 && i_wdata[2:0] == 3'h0 |-> ##2 o_irq_pin_n)
		else $error("pin low while masked");
endmodule : tof_irq_monitor

bind tof_interrupt_and_overflow_limits tof_irq_monitor i_tof_irq_monitor (
	.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_start,
	.i_stop, .o_trigger, .o_running, .o_irq_pin_n);
`default_nettype wire

// *** tof_host_model.sv ***
// Host side of the register port: one-cycle strobes, an idle cycle between writes.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tof_host_model (
	input wire logic i_clk, // Clock
	input wire tof_irq_pkg::byte_t i_rdata, // Read data
	output var tof_irq_pkg::byte_t o_addr, // Address
	output var tof_irq_pkg::byte_t o_wdata, // Write data
	output logic o_wr, // Write strobe
	output logic o_rd // Read strobe
);
	import tof_irq_pkg::*;
	logic just_wr = 1'b0;
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// Gap after a write so the strobe is never lowered and raised at once
	task automatic wr(input byte_t a, input byte_t d);
		if (just_wr) @(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		just_wr = 1'b1;
	endtask : wr
	task automatic rd(input byte_t a, output byte_t d);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		just_wr = 1'b0;
		@(posedge i_clk);
		d = i_rdata;
	endtask : rd
endmodule : tof_host_model
`default_nettype wire

// *** test_tof_interrupt_and_overflow_limits.sv ***
// Self-checking bench for the interrupt and limit block.
// Assumes the host model for register traffic and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_tof_interrupt_and_overflow_limits;
	import tof_irq_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic start = 1'b0;
	logic stop = 1'b0;
	logic tick = 1'b0;
	byte_t addr, wdata, rdata;
	logic wr, rd, trig, running, pin_n;
	word_t clk_cnt, crs_cnt;
	int n_mismatch = 0;
	int n_tests = 0;
	// Address, reset value, write value, read-back value
	logic [31:0] rows [7] = '{32'h0307FF07, 32'h04FF1212, 32'h05FF3434,
		32'h06FF0000, 32'h07FF0505, 32'h0200FF00, 32'h01005500};
	always #5 i_clk = ~i_clk;
	tof_interrupt_and_overflow_limits i_tof_interrupt_and_overflow_limits (
		.i_clk, .i_rst_n, .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_start(start), .i_stop(stop),
		.i_coarse_tick(tick), .o_trigger(trig), .o_running(running),
		.o_irq_pin_n(pin_n), .o_clock_count(clk_cnt),
		.o_coarse_count(crs_cnt));
	tof_host_model i_tof_host_model (.i_clk, .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	task automatic test_done;
		if (n_mismatch == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rchk(input byte_t a, input byte_t exp);
		byte_t d;
		i_tof_host_model.rd(a, d);
		chk(d, exp);
	endtask : rchk
	task automatic wreg(input byte_t a, input byte_t d);
		i_tof_host_model.wr(a, d);
	endtask : wreg
	task automatic begin_run(input logic ticks);
		wreg(8'h00, 8'h01);
		start <= 1'b1;
		tick <= ticks;
		@(posedge i_clk);
		chk(trig, 1'b1);
	endtask : begin_run
	// Bounded wait for the run to end
	task automatic wait_idle;
		repeat (3) @(posedge i_clk);
		for (int k = 0; running === 1'b1; k++) begin
			if (k == 40) begin
				n_mismatch++;
				test_done();
			end
			@(posedge i_clk);
		end
		start <= 1'b0;
		tick <= 1'b0;
	endtask : wait_idle
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		chk(pin_n, 1'b1);
		for (int i = 0; i < 7; i++) begin
			rchk(rows[i][31:24], rows[i][23:16]);
			wreg(rows[i][31:24], rows[i][15:8]);
			rchk(rows[i][31:24], rows[i][7:0]);
		end
		// Run ended by stop, then writing ones to unset bits, then clearing bit 0
		begin_run(1'b0);
		repeat (2) @(posedge i_clk);
		stop <= 1'b1;
		repeat (2) @(posedge i_clk);
		start <= 1'b0;
		stop <= 1'b0;
		chk(pin_n, 1'b0);
		rchk(8'h02, 8'h19);
		wreg(8'h02, 8'h06);
		rchk(8'h02, 8'h19);
		wreg(8'h02, 8'h01);
		rchk(8'h02, 8'h18);
		chk(pin_n, 1'b1);
		// Clock limit of five cuts the run short
		begin_run(1'b0);
		wait_idle();
		rchk(8'h02, 8'h0C);
		chk(clk_cnt, 16'h0005);
		chk(pin_n, 1'b0);
		rchk(8'h00, 8'h00);
		// Coarse limit of three with every interrupt masked
		wreg(8'h03, 8'h00);
		wreg(8'h07, 8'hFF);
		wreg(8'h06, 8'hFF);
		wreg(8'h04, 8'h00);
		wreg(8'h05, 8'h03);
		begin_run(1'b1);
		wait_idle();
		rchk(8'h02, 8'h0A);
		chk(crs_cnt, 16'h0003);
		chk(clk_cnt, 16'h0003);
		chk(pin_n, 1'b1);
		wreg(8'h03, 8'h07);
		repeat (2) @(posedge i_clk);
		chk(pin_n, 1'b0);
		wreg(8'h00, 8'h01);
		rchk(8'h02, 8'h00);
		chk(pin_n, 1'b1);
		// Reset in mid-run restores the status, enable and coarse limit registers
		wreg(8'h03, 8'h01);
		begin_run(1'b0);
		@(posedge i_clk);
		chk(running, 1'b1);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		start <= 1'b0;
		@(posedge i_clk);
		chk(running, 1'b0);
		chk(pin_n, 1'b1);
		rchk(8'h02, 8'h00);
		rchk(8'h03, 8'h07);
		rchk(8'h04, 8'hFF);
		rchk(8'h05, 8'hFF);
		test_done();
	end
endmodule : test_tof_interrupt_and_overflow_limits
`default_nettype wire
